// >>> hdl/sfp_pkg.sv
// shared constants and types of the serial port fifo and interrupt block
package sfp_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W     = 16;
  localparam int AV_AW      = 5;
  localparam int AV_DW      = 32;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [AV_AW-1:0] OFS_CTRL  = 5'h00;
  localparam logic [AV_AW-1:0] OFS_DATA  = 5'h04;
  localparam logic [AV_AW-1:0] OFS_STAT  = 5'h08;
  localparam logic [AV_AW-1:0] OFS_IMASK = 5'h0c;
  localparam logic [AV_AW-1:0] OFS_RAW   = 5'h10;
  localparam logic [AV_AW-1:0] OFS_MIS   = 5'h14;
  localparam logic [AV_AW-1:0] OFS_ICLR  = 5'h18;

  // ---------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_WID_LSB  = 4;
  localparam int CTRL_CPOL_BIT = 8;
  localparam int CTRL_CPHA_BIT = 9;
  localparam int CTRL_OD_BIT   = 10;
  localparam logic [3:0] WID_M1_MIN = 4'h3;
  localparam logic [3:0] WID_M1_RST = 4'hf;
  localparam logic [3:0] IMASK_RST  = 4'h0;

  // ---------------------------------------------------------------
  // status and interrupt bit positions
  // ---------------------------------------------------------------
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_TX_FULL  = 1;
  localparam int ST_RX_EMPTY = 2;
  localparam int ST_RX_FULL  = 3;
  localparam int ST_BUSY     = 4;
  localparam int INT_TXL     = 0;
  localparam int INT_RXL     = 1;
  localparam int INT_RXTO    = 2;
  localparam int INT_RXOR    = 3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS    = 8;
  localparam int RXTO_NS   = 5120;
  localparam int RXTO_CYC  = (RXTO_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // bus handshake states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_PREP = 3'b010,
    BUS_ACK  = 3'b100
  } sfp_bus_t;

endpackage

// >>> hdl/sfp_ram.sv
// small fifo storage with registered read data
`timescale 1ns/100ps
module sfp_ram #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  // clock
  input  wire logic                     clk,
  // write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [W-1:0]             wr_data,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [W-1:0]             rd_data
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// >>> hdl/sfp_top.sv
// serial port fifos, enable, interrupts and avalon register slave
// Notes on behaviour
// RULE_01: receive reads return the frame in low bits up to data width.
// RULE_02: transmit writes keep only low bits up to data width.
// RULE_03: receive fifo empty is shown so a non-blocking read gets nothing.
// RULE_04: transmit fifo full is shown so a non-blocking write is refused.
// RULE_05: clearing enable stops all link activity; setting it starts it.
// RULE_06: software sets format, mode, rate and width before enabling.
// RULE_07: a clear write deasserts that source from the interrupt output.
// RULE_08: only receive timeout and receive overrun are clearable.
// RULE_09: each of four sources has its own mask bit gating the interrupt.
// RULE_10: raw and masked status of all four sources are readable.
// RULE_11: handler should clear early since the clear may lag.
// RULE_12: transmit and receive each have an eight entry 16 bit fifo.
// RULE_13: frame data width is any value from 4 to 16 bits.
// RULE_14: module clock at least 2x bit rate master, 12x slave.
// RULE_15: interrupt output is the or of masked status, every cycle; irq here is registered and follows mis one cycle late.
// RULE_16: overrun on frame into full fifo; timeout on unread idle data.
`timescale 1ns/100ps
module sfp_top #(
  parameter int DEPTH       = sfp_pkg::FIFO_DEPTH,
  parameter int RXTO_CYCLES = sfp_pkg::RXTO_CYC
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // avalon-mm slave
  input  wire logic [sfp_pkg::AV_AW-1:0]  avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [sfp_pkg::AV_DW-1:0]  avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [sfp_pkg::AV_DW-1:0]  avs_readdata,
  output logic                            avs_waitrequest,
  // serial link
  input  wire logic                       link_sclk,
  input  wire logic                       link_cs_n,
  input  wire logic                       link_mosi,
  output logic                            link_miso,
  output logic                            link_miso_oe,
  // interrupt
  output logic                            irq
);
  import sfp_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam int TW = $clog2(RXTO_CYCLES + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_HALF = CW'(DEPTH / 2);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [TW-1:0] TO_LAST  = TW'(RXTO_CYCLES - 1);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [DATA_W-1:0] wmask(input logic [3:0] wm1);
    logic [DATA_W:0] t;
    t = (DATA_W+1)'(1) << ({1'b0, wm1} + 5'h01);
    t = t - (DATA_W+1)'(1);
    return t[DATA_W-1:0];
  endfunction

  function automatic logic [AV_DW-1:0] lanes(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sfp_bus_t          bus_st_r;
  logic              en_r, cpol_r, cpha_r, od_r;
  logic [3:0]        wid_m1_r, imask_r;
  logic              rxto_r, rxor_r;
  logic [PW-1:0]     tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [CW-1:0]     tx_cnt_r, rx_cnt_r, tx_cnt_d_r, rx_cnt_d_r;
  logic [DATA_W-1:0] tx_q, rx_q, wmask_c;
  logic [2:0]        sync1_r, sync2_r;
  logic              sclk_d_r, cs_d_r, in_frame_r, tx_ld_r;
  logic [3:0]        bitcnt_r;
  logic [DATA_W-1:0] rx_sh_r, tx_sh_r;
  logic [TW-1:0]     to_cnt_r;
  logic [AV_DW-1:0]  wdata;
  logic [3:0]        raw, mis;
  logic              acc, wr_go, rd_go, tx_push, tx_pop, rx_push, rx_pop;
  logic              sclk_s, cs_n_s, mosi_s, active, lead, trail, samp, shft;
  logic              fstart, fdone, ovr_ev, to_ev, clr_to, clr_or;
  logic [3:0]        wid_wr;

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  assign acc   = (bus_st_r == BUS_ACK);
  assign wr_go = acc & avs_write;
  assign rd_go = acc & avs_read;
  assign wdata = avs_writedata & lanes(avs_byteenable);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_st_r        <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      unique case (bus_st_r)
        BUS_IDLE: begin
          if (avs_read | avs_write) begin
            bus_st_r <= BUS_PREP;
          end
        end
        BUS_PREP: begin
          bus_st_r        <= BUS_ACK;
          avs_waitrequest <= 1'b0;
        end
        BUS_ACK: begin
          bus_st_r        <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_st_r        <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  assign raw = {rxor_r, rxto_r, rx_cnt_r >= CNT_HALF, tx_cnt_r <= CNT_HALF};
  assign mis = raw & imask_r; // RULE_09

  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_st_r == BUS_PREP && avs_read) begin
      avs_readdata <= 32'h0000_0000;
      unique case (avs_address)
        OFS_CTRL: begin
          avs_readdata[CTRL_EN_BIT]                   <= en_r;
          avs_readdata[CTRL_WID_LSB +: 4]             <= wid_m1_r;
          avs_readdata[CTRL_CPOL_BIT]                 <= cpol_r;
          avs_readdata[CTRL_CPHA_BIT]                 <= cpha_r;
          avs_readdata[CTRL_OD_BIT]                   <= od_r;
        end
        OFS_DATA: begin
          if (rx_cnt_d_r != CNT_ZERO) begin
            avs_readdata[DATA_W-1:0] <= rx_q & wmask_c; // RULE_01
          end
        end
        OFS_STAT: begin
          avs_readdata[ST_TX_EMPTY] <= (tx_cnt_r == CNT_ZERO);
          avs_readdata[ST_TX_FULL]  <= (tx_cnt_r == CNT_FULL); // RULE_04
          avs_readdata[ST_RX_EMPTY] <= (rx_cnt_d_r == CNT_ZERO); // RULE_03
          avs_readdata[ST_RX_FULL]  <= (rx_cnt_r == CNT_FULL);
          avs_readdata[ST_BUSY]     <= in_frame_r;
        end
        OFS_IMASK: avs_readdata[3:0] <= imask_r;
        OFS_RAW:   avs_readdata[3:0] <= raw; // RULE_10
        OFS_MIS:   avs_readdata[3:0] <= mis; // RULE_10
        default:   avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control and mask registers
  // ---------------------------------------------------------------
  assign wid_wr = avs_writedata[CTRL_WID_LSB +: 4];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_r     <= 1'b0;
      wid_m1_r <= WID_M1_RST;
      cpol_r   <= 1'b0;
      cpha_r   <= 1'b0;
      od_r     <= 1'b0;
    end else if (wr_go && avs_address == OFS_CTRL && avs_byteenable[0]) begin
      en_r     <= avs_writedata[CTRL_EN_BIT]; // RULE_05
      wid_m1_r <= (wid_wr < WID_M1_MIN) ? WID_M1_MIN : wid_wr; // RULE_13
      if (avs_byteenable[1]) begin
        cpol_r <= avs_writedata[CTRL_CPOL_BIT];
        cpha_r <= avs_writedata[CTRL_CPHA_BIT];
        od_r   <= avs_writedata[CTRL_OD_BIT];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      imask_r <= IMASK_RST;
    end else if (wr_go && avs_address == OFS_IMASK && avs_byteenable[0]) begin
      imask_r <= avs_writedata[3:0]; // RULE_09
    end
  end

  assign wmask_c = wmask(wid_m1_r);

  // ---------------------------------------------------------------
  // fifo pointers and counts
  // ---------------------------------------------------------------
  assign tx_push = wr_go && avs_address == OFS_DATA && tx_cnt_r != CNT_FULL; // RULE_04
  assign rx_pop  = rd_go && avs_address == OFS_DATA && rx_cnt_d_r != CNT_ZERO; // RULE_03

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_wp_r    <= '0;
      tx_rp_r    <= '0;
      tx_cnt_r   <= '0;
      tx_cnt_d_r <= '0;
    end else begin
      tx_wp_r    <= tx_wp_r + PW'(tx_push);
      tx_rp_r    <= tx_rp_r + PW'(tx_pop);
      tx_cnt_r   <= tx_cnt_r + CW'(tx_push) - CW'(tx_pop);
      tx_cnt_d_r <= tx_cnt_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_wp_r    <= '0;
      rx_rp_r    <= '0;
      rx_cnt_r   <= '0;
      rx_cnt_d_r <= '0;
    end else begin
      rx_wp_r    <= rx_wp_r + PW'(rx_push);
      rx_rp_r    <= rx_rp_r + PW'(rx_pop);
      rx_cnt_r   <= rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
      rx_cnt_d_r <= rx_cnt_r;
    end
  end

  // RULE_12
  sfp_ram #(.W(DATA_W), .DEPTH(DEPTH)) u_tx_ram (
    .clk     (core_clk),
    .wr_en   (tx_push),
    .wr_addr (tx_wp_r),
    .wr_data (wdata[DATA_W-1:0] & wmask_c), // RULE_02
    .rd_addr (tx_rp_r),
    .rd_data (tx_q)
  );

  sfp_ram #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_ram (
    .clk     (core_clk),
    .wr_en   (rx_push),
    .wr_addr (rx_wp_r),
    .wr_data ({rx_sh_r[DATA_W-2:0], mosi_s} & wmask_c), // RULE_01
    .rd_addr (rx_rp_r),
    .rd_data (rx_q)
  );

  // ---------------------------------------------------------------
  // link input synchronisers and edges
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_r  <= 3'h2;
      sync2_r  <= 3'h2;
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      sync1_r  <= {link_mosi, link_cs_n, link_sclk};
      sync2_r  <= sync1_r;
      sclk_d_r <= sync2_r[0];
      cs_d_r   <= sync2_r[1];
    end
  end

  assign sclk_s = sync2_r[0];
  assign cs_n_s = sync2_r[1];
  assign mosi_s = sync2_r[2];
  assign active = en_r & ~cs_n_s; // RULE_05
  assign lead   = (sclk_d_r == cpol_r) && (sclk_s != cpol_r);
  assign trail  = (sclk_d_r != cpol_r) && (sclk_s == cpol_r);
  assign samp   = cpha_r ? trail : lead;
  assign shft   = cpha_r ? lead : trail;
  assign fstart = en_r & cs_d_r & ~cs_n_s;
  assign fdone  = in_frame_r & active & samp & (bitcnt_r == wid_m1_r);
  assign rx_push = fdone & (rx_cnt_r != CNT_FULL);
  assign ovr_ev  = fdone & (rx_cnt_r == CNT_FULL); // RULE_16
  assign tx_pop  = fdone & tx_ld_r;

  // ---------------------------------------------------------------
  // frame shifter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_frame_r   <= 1'b0;
      tx_ld_r      <= 1'b0;
      bitcnt_r     <= 4'h0;
      rx_sh_r      <= 16'h0000;
      tx_sh_r      <= 16'h0000;
      link_miso    <= 1'b0;
      link_miso_oe <= 1'b0;
    end else begin
      link_miso_oe <= active & ~od_r;
      if (!active) begin
        in_frame_r <= 1'b0; // RULE_05
        tx_ld_r    <= 1'b0;
      end else if (fstart) begin
        in_frame_r <= 1'b1;
        bitcnt_r   <= 4'h0;
        tx_ld_r    <= (tx_cnt_d_r != CNT_ZERO);
        if (tx_cnt_d_r == CNT_ZERO) begin
          tx_sh_r   <= 16'h0000;
          link_miso <= 1'b0;
        end else if (cpha_r) begin
          tx_sh_r <= tx_q;
        end else begin
          tx_sh_r   <= tx_q << 1;
          link_miso <= tx_q[wid_m1_r];
        end
      end else if (in_frame_r) begin
        if (samp) begin
          rx_sh_r  <= {rx_sh_r[DATA_W-2:0], mosi_s};
          bitcnt_r <= bitcnt_r + 4'h1;
        end
        if (fdone) begin
          in_frame_r <= 1'b0;
          tx_ld_r    <= 1'b0;
        end
        if (shft) begin
          link_miso <= tx_sh_r[wid_m1_r];
          tx_sh_r   <= tx_sh_r << 1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // receive timeout
  // ---------------------------------------------------------------
  assign to_ev = (to_cnt_r == TO_LAST);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      to_cnt_r <= '0;
    end else if (rx_push || rx_pop || rx_cnt_r == CNT_ZERO) begin
      to_cnt_r <= '0;
    end else if (to_cnt_r != TW'(RXTO_CYCLES)) begin
      to_cnt_r <= to_cnt_r + TW'(1); // RULE_16
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and output
  // ---------------------------------------------------------------
  assign clr_to = wr_go && avs_address == OFS_ICLR && avs_byteenable[0]
                  && avs_writedata[INT_RXTO]; // RULE_08
  assign clr_or = wr_go && avs_address == OFS_ICLR && avs_byteenable[0]
                  && avs_writedata[INT_RXOR]; // RULE_08

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxto_r <= 1'b0;
      rxor_r <= 1'b0;
    end else begin
      rxto_r <= to_ev | (rxto_r & ~clr_to); // RULE_07
      rxor_r <= ovr_ev | (rxor_r & ~clr_or); // RULE_07
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |mis; // RULE_15
    end
  end

endmodule

// >>> test/sfp_lnk_mdl.sv
// far-side link master model driving frames into the serial port
`timescale 1ns/100ps
module sfp_lnk_mdl (
  // link out
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_mosi,
  // link in
  input  wire logic link_miso,
  input  wire logic link_miso_oe
);
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_mosi = 1'b0;
  end

  // ---------------------------------------------------------------
  // one frame, msb first, clock still between frames
  // ---------------------------------------------------------------
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx, output logic oe);
    rx = 16'h0;
    oe = 1'b0;
    #3.3 link_cs_n = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      link_mosi = tx[i];
      #80 link_sclk = 1'b1;
      rx = {rx[14:0], link_miso};
      oe = oe | link_miso_oe;
      #80 link_sclk = 1'b0;
    end
    #80 link_cs_n = 1'b1;
    link_mosi = ~link_mosi;
    #80;
  endtask
endmodule

// >>> test/sfp_chk_sva.sv
// port assertions of the serial port fifo and interrupt block
`timescale 1ns/100ps
module sfp_chk #(
  parameter int DEPTH       = 8,
  parameter int RXTO_CYCLES = 16
) (
  // clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst,
  // avalon-mm slave
  input wire logic [sfp_pkg::AV_AW-1:0] avs_address,
  input wire logic                      avs_read,
  input wire logic                      avs_write,
  input wire logic [sfp_pkg::AV_DW-1:0] avs_writedata,
  input wire logic [3:0]                avs_byteenable,
  input wire logic [sfp_pkg::AV_DW-1:0] avs_readdata,
  input wire logic                      avs_waitrequest,
  // link and interrupt
  input wire logic                      link_sclk,
  input wire logic                      link_cs_n,
  input wire logic                      link_mosi,
  input wire logic                      link_miso,
  input wire logic                      link_miso_oe,
  input wire logic                      irq
);
  import sfp_pkg::*;
  logic       rd_done;
  logic       wr_done;
  logic       en_r;
  logic [3:0] wid_r;
  logic [3:0] mask_r;
  logic [3:0] idle_r;
  assign rd_done = avs_read && !avs_waitrequest;
  assign wr_done = avs_write && !avs_waitrequest;

  // ---------------------------------------------------------------
  // shadow of control, mask and idle time
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wid_r <= WID_M1_RST;
      en_r  <= 1'b0;
    end else if (wr_done && avs_address == OFS_CTRL && avs_byteenable[0]) begin
      wid_r <= (avs_writedata[7:4] < WID_M1_MIN) ? WID_M1_MIN : avs_writedata[7:4];
      en_r  <= avs_writedata[CTRL_EN_BIT];
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_r <= IMASK_RST;
    end else if (wr_done && avs_address == OFS_IMASK) begin
      mask_r <= avs_writedata[3:0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst || (en_r && !link_cs_n)) begin
      idle_r <= 4'h0;
    end else if (idle_r != 4'hf) begin
      idle_r <= idle_r + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_answer; $rose(avs_read || avs_write) |-> ##[1:4] !avs_waitrequest; endproperty
  property p_rx_width;
    rd_done && avs_address == OFS_DATA |->
      (avs_readdata & ~((32'h2 << wid_r) - 32'h1)) == 32'h0;
  endproperty
  property p_stat;
    rd_done && avs_address == OFS_STAT |->
      !(avs_readdata[ST_TX_EMPTY] && avs_readdata[ST_TX_FULL]) &&
      !(avs_readdata[ST_RX_EMPTY] && avs_readdata[ST_RX_FULL]);
  endproperty
  property p_mis;
    rd_done && avs_address == OFS_MIS |-> (avs_readdata & ~{28'h0, mask_r}) == 32'h0;
  endproperty
  property p_irq_mis; rd_done && avs_address == OFS_MIS |-> irq == (|avs_readdata[3:0]);
  endproperty
  property p_mask_irq; mask_r == 4'h0 && $past(mask_r) == 4'h0 |-> !irq; endproperty
  property p_clr;
    wr_done && avs_address == OFS_ICLR && avs_writedata[3:2] == 2'b11 &&
      mask_r[1:0] == 2'h0 |-> ##2 !irq;
  endproperty
  property p_lvl_keep;
    wr_done && avs_address == OFS_ICLR && irq && mask_r[3:2] == 2'h0 |-> ##2 irq;
  endproperty
  property p_idle_oe; idle_r >= 4'h8 |-> !link_miso_oe; endproperty

  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  a_answer: assert property (p_answer) else $error("request not answered");
  a_rx_width: assert property (p_rx_width) else $error("rx bits above width");
  a_stat: assert property (p_stat) else $error("status full and empty");
  a_mis: assert property (p_mis) else $error("masked status not masked");
  a_irq_mis: assert property (p_irq_mis) else $error("irq not or of mis");
  a_mask_irq: assert property (p_mask_irq) else $error("irq while all masked");
  a_clr: assert property (p_clr) else $error("clear left irq high");
  a_lvl_keep: assert property (p_lvl_keep) else $error("level source cleared");
  a_idle_oe: assert property (p_idle_oe) else $error("miso driven while idle");
  c_rx_read: cover property (rd_done && avs_address == OFS_DATA);
  c_clear: cover property (wr_done && avs_address == OFS_ICLR);
  c_irq: cover property ($rose(irq));
endmodule

bind sfp_top sfp_chk #(.DEPTH(DEPTH), .RXTO_CYCLES(RXTO_CYCLES)) chk_u (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_sclk(link_sclk),
  .link_cs_n(link_cs_n), .link_mosi(link_mosi), .link_miso(link_miso),
  .link_miso_oe(link_miso_oe), .irq(irq));

// >>> test/tb.sv
// self-checking bench of the serial port fifo and interrupt block
`timescale 1ns/100ps
module tb;
  import sfp_pkg::*;
  logic             core_clk;
  logic             rst;
  logic [AV_AW-1:0] avs_address;
  logic             avs_read;
  logic             avs_write;
  logic [AV_DW-1:0] avs_writedata;
  logic [AV_DW-1:0] avs_readdata;
  logic [AV_DW-1:0] q;
  logic [3:0]       avs_byteenable;
  logic             avs_waitrequest;
  logic             link_sclk;
  logic             link_cs_n;
  logic             link_mosi;
  logic             link_miso;
  logic             link_miso_oe;
  logic             irq;
  logic [15:0]      rx;
  logic             oe;
  int               n_errors;
  int               checked;

  always #4 core_clk = ~core_clk;

  sfp_top #(.DEPTH(FIFO_DEPTH), .RXTO_CYCLES(16)) dut_u (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_sclk(link_sclk),
    .link_cs_n(link_cs_n), .link_mosi(link_mosi), .link_miso(link_miso),
    .link_miso_oe(link_miso_oe), .irq(irq));
  sfp_lnk_mdl lm_u (
    .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_mosi(link_mosi),
    .link_miso(link_miso), .link_miso_oe(link_miso_oe));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [AV_AW-1:0] a, input logic [AV_DW-1:0] d);
    int n;
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (n >= 20) chk(32'(n), 32'h0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [AV_AW-1:0] a, input logic [AV_DW-1:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [AV_AW-1:0] a, input logic [AV_DW-1:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #300000;
    n_errors++;
    end_sim;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    n_errors = 0;
    checked = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    // reset values and unmapped place
    rd(OFS_CTRL, 32'hf0);
    rd(OFS_IMASK, 32'h0);
    rd(OFS_STAT, 32'h5);
    rd(OFS_RAW, 32'h1);
    wr(5'h1c, '1);
    rd(5'h1c, 32'h0);
    chk(irq, 32'h0);
    // width first, then enable, then one frame
    wr(OFS_CTRL, 32'h70);
    wr(OFS_CTRL, 32'h71);
    wr(OFS_DATA, 32'habcd1234);
    lm_u.frame(16'ha5, 8, rx, oe);
    chk(rx, 32'h34);
    rd(OFS_DATA, 32'ha5);
    // fill tx until refused, overrun rx
    for (int j = 0; j < 8; j++) wr(OFS_DATA, 32'hc3c3c300 | j);
    rd(OFS_STAT, 32'h6);
    bus(1'b0, OFS_RAW, 32'h0);
    chk(q & 32'h3, 32'h0);
    wr(OFS_DATA, 32'h99);
    for (int j = 0; j < 9; j++) begin
      lm_u.frame(16'(16'h40 + j), 8, rx, oe);
      chk(rx, (j < 8) ? 32'(j) : 32'h0);
    end
    rd(OFS_STAT, 32'h9);
    rd(OFS_RAW, 32'hf);
    idle(2);
    chk(irq, 32'h0);
    // mask, clear and level sources
    wr(OFS_IMASK, 32'h8);
    idle(3);
    chk(irq, 32'h1);
    rd(OFS_MIS, 32'h8);
    wr(OFS_ICLR, 32'hf);
    rd(OFS_RAW, 32'h3);
    chk(irq, 32'h0);
    wr(OFS_IMASK, 32'h3);
    idle(3);
    chk(irq, 32'h1);
    wr(OFS_ICLR, 32'h3);
    idle(3);
    chk(irq, 32'h1);
    wr(OFS_IMASK, 32'h0);
    idle(3);
    chk(irq, 32'h0);
    // drain rx until empty
    for (int j = 0; j < 8; j++) rd(OFS_DATA, 32'h40 + j);
    rd(OFS_DATA, 32'h0);
    wr(OFS_STAT, '1);
    rd(OFS_STAT, 32'h5);
    // disabled port ignores the link
    wr(OFS_CTRL, 32'h70);
    lm_u.frame(16'h77, 8, rx, oe);
    chk(oe, 32'h0);
    rd(OFS_STAT, 32'h5);
    // narrowest width, re-enabled
    wr(OFS_CTRL, 32'h01);
    rd(OFS_CTRL, 32'h31);
    lm_u.frame(16'h9, 4, rx, oe);
    chk(oe, 32'h1);
    rd(OFS_DATA, 32'h9);
    // output disable keeps miso released
    wr(OFS_CTRL, 32'h431);
    rd(OFS_CTRL, 32'h431);
    lm_u.frame(16'h6, 4, rx, oe);
    chk(oe, 32'h0);
    rd(OFS_DATA, 32'h6);
    end_sim;
  end
endmodule
